/* logic/pmc_pkg.sv */
package pmc_pkg;

	// Time base
	localparam int CLK_PERIOD_NS  = 50;
	localparam int NS_PER_MS      = 1000000;
	localparam int NS_PER_KHZ     = 1000000;

	// Wake and start-up latency
	localparam int WAKE_TIME_MS   = 7;
	localparam int WAKE_CYC       = (WAKE_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;
	localparam int WAKE_W         = 18;

	// Bit clock bands
	localparam int SLEEP_FREQ_KHZ = 200;
	localparam int WAKE_FREQ_KHZ  = 250;
	localparam int LP_NOM_KHZ     = 768;
	localparam int LP_LO_KHZ      = 400;
	localparam int LP_HI_KHZ      = 1000;
	localparam int SLEEP_PER_CYC  = (NS_PER_KHZ / SLEEP_FREQ_KHZ) / CLK_PERIOD_NS;
	localparam int WAKE_PER_CYC   = (NS_PER_KHZ / WAKE_FREQ_KHZ) / CLK_PERIOD_NS;
	localparam int LP_MIN_CYC     = (NS_PER_KHZ / LP_HI_KHZ) / CLK_PERIOD_NS;
	localparam int LP_MAX_CYC     = (NS_PER_KHZ / LP_LO_KHZ) / CLK_PERIOD_NS;
	localparam int PER_W          = 8;
	localparam int AGREE_CNT      = 4;
	localparam int AGREE_W        = 3;

	// Strap capture delay after reset release
	localparam int SEL_DLY        = 2;

	// Sample path
	localparam int SAMPLE_W       = 16;
	localparam int ACC_W          = 18;
	localparam int BUF_DEPTH      = 2;
	localparam logic signed [SAMPLE_W-1:0] FULL_SCALE = 16'sh7fff;

	typedef enum logic [1:0]
	{
		PMC_NORMAL    = 2'b00,
		PMC_LOW_POWER = 2'b01,
		PMC_SLEEP     = 2'b10
	} pmc_mode_e;

	localparam pmc_mode_e MODE_RST = PMC_SLEEP;

	typedef struct packed
	{
		logic      rise;
		logic      fall;
		pmc_mode_e mode;
	} pmc_rate_s;

endpackage : pmc_pkg

/* logic/pmc_buf2.sv */
`timescale 1ns/1ps
module pmc_buf2
#(
	parameter int WIDTH = pmc_pkg::SAMPLE_W,
	parameter int DEPTH = pmc_pkg::BUF_DEPTH
)
(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [CW-1:0]    count_r;
	logic [CW-1:0]    count_nxt;
	logic             push;
	logic             pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction : ptr_inc

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (count_r != '0);
	assign out_data  = mem[rd_ptr_r];

	always_comb
	begin
		count_nxt = count_r;
		if (push && !pop)
			count_nxt = count_r + CW'(1);
		else if (pop && !push)
			count_nxt = count_r - CW'(1);
	end

	// Storage
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	// Pointers and fill level
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			in_ready <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= ptr_inc(wr_ptr_r);
			if (pop)
				rd_ptr_r <= ptr_inc(rd_ptr_r);
			count_r  <= count_nxt;
			in_ready <= (count_nxt != CW'(DEPTH));
		end
	end

endmodule : pmc_buf2

/* logic/pmc_rate_detect.sv */
`timescale 1ns/1ps
module pmc_rate_detect
(
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic          bit_clk,
	output pmc_pkg::pmc_rate_s rate
);
	logic                    bclk_meta_r;
	logic                    bclk_sync_r;
	logic                    bclk_prev_r;
	logic                    rise;
	logic                    fall;
	logic [pmc_pkg::PER_W-1:0]   per_cnt_r;
	logic [pmc_pkg::AGREE_W-1:0] agree_r;
	pmc_pkg::pmc_mode_e      cand_r;
	pmc_pkg::pmc_mode_e      cand;
	pmc_pkg::pmc_mode_e      mode_r;
	logic                    timeout;

	// Period in cycles to mode, with a wider sleep band while already in sleep
	function automatic pmc_pkg::pmc_mode_e classify(
		input logic [pmc_pkg::PER_W-1:0] per,
		input pmc_pkg::pmc_mode_e        cur
	);
		if (per > pmc_pkg::PER_W'(pmc_pkg::SLEEP_PER_CYC))
			classify = pmc_pkg::PMC_SLEEP;
		else if (cur == pmc_pkg::PMC_SLEEP && per > pmc_pkg::PER_W'(pmc_pkg::WAKE_PER_CYC))
			classify = pmc_pkg::PMC_SLEEP;
		else if (per >= pmc_pkg::PER_W'(pmc_pkg::LP_MIN_CYC)
			&& per <= pmc_pkg::PER_W'(pmc_pkg::LP_MAX_CYC))
			classify = pmc_pkg::PMC_LOW_POWER;
		else
			classify = pmc_pkg::PMC_NORMAL;
	endfunction : classify

	assign rise    = bclk_sync_r && !bclk_prev_r;
	assign fall    = !bclk_sync_r && bclk_prev_r;
	assign timeout = (per_cnt_r == pmc_pkg::PER_W'(pmc_pkg::SLEEP_PER_CYC)) && !rise;
	assign cand    = classify(per_cnt_r + pmc_pkg::PER_W'(1), mode_r);

	// Pin synchroniser and edge finder
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			bclk_meta_r <= 1'b0;
			bclk_sync_r <= 1'b0;
			bclk_prev_r <= 1'b0;
		end
		else
		begin
			bclk_meta_r <= bit_clk;
			bclk_sync_r <= bclk_meta_r;
			bclk_prev_r <= bclk_sync_r;
		end
	end

	// Period counter, saturating past the sleep threshold
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			per_cnt_r <= '0;
		else if (rise)
			per_cnt_r <= '0;
		else if (per_cnt_r <= pmc_pkg::PER_W'(pmc_pkg::SLEEP_PER_CYC))
			per_cnt_r <= per_cnt_r + pmc_pkg::PER_W'(1);
	end

	// Mode filter: agreeing periods before a change
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cand_r  <= pmc_pkg::MODE_RST;
			agree_r <= '0;
			mode_r  <= pmc_pkg::MODE_RST;
		end
		else if (timeout)
		begin
			cand_r  <= pmc_pkg::PMC_SLEEP;
			agree_r <= '0;
			mode_r  <= pmc_pkg::PMC_SLEEP;
		end
		else if (rise)
		begin
			cand_r <= cand;
			if (cand != cand_r)
				agree_r <= '0;
			else if (agree_r != pmc_pkg::AGREE_W'(pmc_pkg::AGREE_CNT - 1))
				agree_r <= agree_r + pmc_pkg::AGREE_W'(1);
			else
				mode_r <= cand_r;
		end
	end

	// Registered edge pulses and mode
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			rate <= '{rise: 1'b0, fall: 1'b0, mode: pmc_pkg::MODE_RST};
		else
			rate <= '{rise: rise, fall: fall, mode: mode_r};
	end

endmodule : pmc_rate_detect

/* logic/pmc_mic.sv */
`timescale 1ns/1ps
module pmc_mic
#(
	parameter int WAKE_CYCLES = pmc_pkg::WAKE_CYC
)
(
	input  wire logic                         CLK,
	input  wire logic                         RESET,
	input  wire logic                         BIT_CLK,
	input  wire logic                         CHANNEL_SELECT,
	input  wire logic [pmc_pkg::SAMPLE_W-1:0] SAMPLE_DATA,
	input  wire logic                         SAMPLE_VALID,
	output logic                              SAMPLE_READY,
	output logic                              DATA_OUT,
	output logic                              DATA_OE,
	output logic                              LOW_POWER_LISTEN_MODE,
	output logic                              SLEEP_MODE,
	output logic                              DATA_SETTLED
);
	localparam int SW = pmc_pkg::SAMPLE_W;
	localparam int AW = pmc_pkg::ACC_W;

	pmc_pkg::pmc_rate_s        rate;
	logic                      sel_meta_r;
	logic                      sel_sync_r;
	logic [1:0]                sel_cnt_r;
	logic                      sel_done_r;
	logic                      left_slot_r;
	logic [pmc_pkg::WAKE_W-1:0] wake_cnt_r;
	logic                      settled_r;
	logic                      active;
	logic                      own_edge;
	logic                      other_edge;
	logic                      lp_skip_r;
	logic                      take;
	logic [SW-1:0]             buf_data;
	logic                      buf_valid;
	logic signed [SW-1:0]      hold_r;
	logic signed [SW-1:0]      cur;
	logic signed [AW-1:0]      acc_r;
	logic                      bit_nxt;

	// Clamp a sample to the symmetric full-scale range
	function automatic logic signed [SW-1:0] clamp_fs(input logic signed [SW-1:0] x);
		if (x > pmc_pkg::FULL_SCALE)
			clamp_fs = pmc_pkg::FULL_SCALE;
		else if (x < -pmc_pkg::FULL_SCALE)
			clamp_fs = -pmc_pkg::FULL_SCALE;
		else
			clamp_fs = x;
	endfunction : clamp_fs

	// Integrator step, bounded to twice full scale
	function automatic logic signed [AW-1:0] integ(
		input logic signed [AW-1:0] acc,
		input logic signed [SW-1:0] x
	);
		logic signed [AW-1:0] fs;
		logic signed [AW-1:0] fb;
		logic signed [AW:0]   sum;
		fs  = AW'(pmc_pkg::FULL_SCALE);
		fb  = (acc >= 0) ? fs : -fs;
		sum = (AW+1)'(acc) + (AW+1)'(x) - (AW+1)'(fb);
		if (sum > (AW+1)'(2 * fs))
			integ = AW'(2 * fs);
		else if (sum < -(AW+1)'(2 * fs))
			integ = -AW'(2 * fs);
		else
			integ = sum[AW-1:0];
	endfunction : integ

	pmc_rate_detect u_rate
	(
		.clk     (CLK),
		.reset   (RESET),
		.bit_clk (BIT_CLK),
		.rate    (rate)
	);

	pmc_buf2
	#(
		.WIDTH (SW),
		.DEPTH (pmc_pkg::BUF_DEPTH)
	)
	u_buf
	(
		.clk       (CLK),
		.reset     (RESET),
		.in_data   (SAMPLE_DATA),
		.in_valid  (SAMPLE_VALID),
		.in_ready  (SAMPLE_READY),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (take)
	);

	// Strap synchroniser
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			sel_meta_r <= 1'b0;
			sel_sync_r <= 1'b0;
		end
		else
		begin
			sel_meta_r <= CHANNEL_SELECT;
			sel_sync_r <= sel_meta_r;
		end
	end

	// Strap caught once after reset release, then frozen
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			sel_cnt_r   <= '0;
			sel_done_r  <= 1'b0;
			left_slot_r <= 1'b0;
		end
		else if (!sel_done_r)
		begin
			if (sel_cnt_r == 2'(pmc_pkg::SEL_DLY))
			begin
				left_slot_r <= sel_sync_r;
				sel_done_r  <= 1'b1;
			end
			else
				sel_cnt_r <= sel_cnt_r + 2'd1;
		end
	end

	// Settling timer from clock start or power-up
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			wake_cnt_r <= '0;
			settled_r  <= 1'b0;
		end
		else if (rate.mode == pmc_pkg::PMC_SLEEP)
		begin
			wake_cnt_r <= '0;
			settled_r  <= 1'b0;
		end
		else if (wake_cnt_r >= pmc_pkg::WAKE_W'(WAKE_CYCLES - 1))
			settled_r <= 1'b1;
		else
			wake_cnt_r <= wake_cnt_r + pmc_pkg::WAKE_W'(1);
	end

	assign active     = settled_r && sel_done_r && rate.mode != pmc_pkg::PMC_SLEEP;
	assign own_edge   = left_slot_r ? rate.fall : rate.rise;
	assign other_edge = left_slot_r ? rate.rise : rate.fall;
	// Low-power mode takes a new sample every second bit
	assign take       = active && own_edge && !lp_skip_r;
	assign cur        = clamp_fs((take && buf_valid) ? $signed(buf_data) : hold_r);
	assign bit_nxt    = (integ(acc_r, cur) >= 0);

	// Reduced-activity toggle
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			lp_skip_r <= 1'b0;
		else if (rate.mode != pmc_pkg::PMC_LOW_POWER)
			lp_skip_r <= 1'b0;
		else if (active && own_edge)
			lp_skip_r <= !lp_skip_r;
	end

	// Modulator state
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			hold_r <= '0;
			acc_r  <= '0;
		end
		else if (!active)
			acc_r <= '0;
		else if (own_edge)
		begin
			hold_r <= cur;
			acc_r  <= integ(acc_r, cur);
		end
	end

	// Slot driver on the shared line
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			DATA_OUT <= 1'b0;
			DATA_OE  <= 1'b0;
		end
		else if (!active)
			DATA_OE <= 1'b0;
		else if (own_edge)
		begin
			DATA_OUT <= bit_nxt;
			DATA_OE  <= 1'b1;
		end
		else if (other_edge)
			DATA_OE <= 1'b0;
	end

	// Status outputs
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			LOW_POWER_LISTEN_MODE <= 1'b0;
			SLEEP_MODE            <= 1'b1;
			DATA_SETTLED          <= 1'b0;
		end
		else
		begin
			LOW_POWER_LISTEN_MODE <= (rate.mode == pmc_pkg::PMC_LOW_POWER);
			SLEEP_MODE            <= (rate.mode == pmc_pkg::PMC_SLEEP);
			DATA_SETTLED          <= active;
		end
	end

endmodule : pmc_mic

/* verification/pmc_mic_props.sv */
`timescale 1ns/1ps
module pmc_mic_props
#(
	parameter int WAKE_CYCLES = 200
)
(
	input wire logic                         CLK,
	input wire logic                         RESET,
	input wire logic                         BIT_CLK,
	input wire logic                         CHANNEL_SELECT,
	input wire logic [pmc_pkg::SAMPLE_W-1:0] SAMPLE_DATA,
	input wire logic                         SAMPLE_VALID,
	input wire logic                         SAMPLE_READY,
	input wire logic                         DATA_OUT,
	input wire logic                         DATA_OE,
	input wire logic                         LOW_POWER_LISTEN_MODE,
	input wire logic                         SLEEP_MODE,
	input wire logic                         DATA_SETTLED
);
	logic [1:0]  rst_cnt_r;
	logic        sel_r;
	logic        bclk_r;
	logic [7:0]  run_r;
	logic [7:0]  per_r;
	logic [17:0] awake_r;

	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);

	// Strap copy, bit clock period, time awake
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			rst_cnt_r <= 2'h0;
			sel_r     <= 1'b0;
			bclk_r    <= 1'b0;
			run_r     <= 8'h00;
			per_r     <= 8'h00;
			awake_r   <= 18'h0_0000;
		end
		else
		begin
			bclk_r <= BIT_CLK;
			if (rst_cnt_r != 2'h3)
				rst_cnt_r <= rst_cnt_r + 2'h1;
			if (rst_cnt_r == 2'h2)
				sel_r <= CHANNEL_SELECT;
			if (BIT_CLK && !bclk_r)
			begin
				per_r <= run_r;
				run_r <= 8'h01;
			end
			else if (run_r != 8'hff)
				run_r <= run_r + 8'h01;
			if (SLEEP_MODE)
				awake_r <= 18'h0_0000;
			else if (awake_r != 18'h3_ffff)
				awake_r <= awake_r + 18'h0_0001;
		end
	end

	property p_sleep_quiet;
		SLEEP_MODE |-> !DATA_OE && !DATA_SETTLED;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet)
		else $error("pin driven or settled in sleep");
	property p_oe_settled;
		DATA_OE |-> DATA_SETTLED;
	endproperty
	a_oe_settled: assert property (p_oe_settled)
		else $error("pin driven before settling");
	property p_mode_excl;
		!(SLEEP_MODE && LOW_POWER_LISTEN_MODE);
	endproperty
	a_mode_excl: assert property (p_mode_excl)
		else $error("two modes at once");
	property p_settle_time;
		$rose(DATA_SETTLED) |-> awake_r >= WAKE_CYCLES - 2 && awake_r <= WAKE_CYCLES + 4;
	endproperty
	a_settle_time: assert property (p_settle_time)
		else $error("settle time wrong");
	property p_timeout;
		run_r == 8'h6e |-> SLEEP_MODE;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("no sleep on stopped clock");
	property p_release;
		(sel_r ? $rose(BIT_CLK) : $fell(BIT_CLK)) |-> ##[2:6] !DATA_OE;
	endproperty
	a_release: assert property (p_release)
		else $error("pin not released");
	property p_drive_edge;
		$rose(DATA_OE) |-> $past(BIT_CLK, 3) != sel_r;
	endproperty
	a_drive_edge: assert property (p_drive_edge)
		else $error("drive in wrong half");
	property p_lp_band;
		$rose(LOW_POWER_LISTEN_MODE) |-> per_r >= 8'h14 && per_r <= 8'h32;
	endproperty
	a_lp_band: assert property (p_lp_band)
		else $error("low power outside band");

	c_lp: cover property ($rose(LOW_POWER_LISTEN_MODE));
	c_settle: cover property ($rose(DATA_SETTLED));
	c_sleep: cover property ($rose(SLEEP_MODE));
endmodule : pmc_mic_props

bind pmc_mic pmc_mic_props #(.WAKE_CYCLES(WAKE_CYCLES)) u_pmc_mic_props
(
	.CLK, .RESET, .BIT_CLK, .CHANNEL_SELECT, .SAMPLE_DATA, .SAMPLE_VALID, .SAMPLE_READY,
	.DATA_OUT, .DATA_OE, .LOW_POWER_LISTEN_MODE, .SLEEP_MODE, .DATA_SETTLED
);

/* verification/pmc_host_model.sv */
`timescale 1ns/1ps
module pmc_host_model
(
	input  wire logic run,
	input  wire logic sel,
	input  var  int   half_ns,
	input  wire logic data_out,
	input  wire logic data_oe,
	output logic      bit_clk,
	output int        bits,
	output int        ones,
	output int        drv
);
	logic        line;
	logic        last;
	logic [19:0] acc;

	initial bit_clk = 1'b0;
	initial acc = 20'h0_0000;

	// Clock made here, still while stopped
	always
	begin
		if (run)
			#half_ns bit_clk = ~bit_clk;
		else
		begin
			bit_clk = 1'b0;
			wait (run);
		end
	end

	// Released line holds no stale level
	always @(data_out or data_oe)
		if (data_oe)
			last = data_out;
	assign line = data_oe ? data_out : ~last;

	// Own slot sampled at end of its half
	always @(bit_clk)
	begin
		if (bit_clk == sel)
		begin
			bits = bits + 1;
			ones = ones + int'(line);
			drv = drv + int'(data_oe);
			acc = acc + {19'h0_0000, line};
		end
	end
endmodule : pmc_host_model

/* verification/test_pmc_mic.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module test_pmc_mic;
	localparam int WAKE = 200;
	logic        clk = 0;
	logic        reset = 1;
	logic        sel = 0;
	logic        msel = 0;
	logic        run = 0;
	logic [15:0] sdata = 16'h0000;
	logic        svalid = 0;
	int          half = 200;
	logic        sready, dout, doe, low_power_listen_mode, slp, settled, bclk;
	int          bits, ones, drv, bad_count, cmp_count, cyc, n;

	always #25 clk = ~clk;

	pmc_mic #(.WAKE_CYCLES(WAKE)) u_pmc_mic (.CLK(clk), .RESET(reset), .BIT_CLK(bclk),
		.CHANNEL_SELECT(sel), .SAMPLE_DATA(sdata), .SAMPLE_VALID(svalid),
		.SAMPLE_READY(sready), .DATA_OUT(dout), .DATA_OE(doe),
		.LOW_POWER_LISTEN_MODE(low_power_listen_mode), .SLEEP_MODE(slp), .DATA_SETTLED(settled));
	pmc_host_model u_pmc_host_model (.run(run), .sel(msel), .half_ns(half),
		.data_out(dout), .data_oe(doe), .bit_clk(bclk), .bits(bits), .ones(ones), .drv(drv));

	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			print_verdict();
		end
	end

	task do_reset(input logic s);
		@(negedge clk);
		sel = s;
		msel = s;
		reset = 1;
		repeat (2) @(negedge clk);
		reset = 0;
	endtask : do_reset

	task wait_settled;
		n = 0;
		while (settled !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
	endtask : wait_settled

	task t_stream(input logic [15:0] v, input int lo, input int hi, input string nm);
		int b0, o0, d0;
		sdata = v;
		b0 = bits;
		o0 = ones;
		d0 = drv;
		repeat (400) @(negedge clk);
		`CHK(nm, 1'b1, ((ones - o0) * 100 >= lo * (bits - b0)))
		`CHK(nm, 1'b1, ((ones - o0) * 100 <= hi * (bits - b0)))
		`CHK("drv", bits - b0, drv - d0)
		$display("stream %s done", nm);
	endtask : t_stream

	task t_wake;
		run = 1;
		svalid = 1;
		do_reset(0);
		wait_settled();
		`CHK("wake", 1'b1, (n >= WAKE && n <= WAKE + 80))
		`CHK("sleep", 1'b0, slp)
		`CHK("lpm", 1'b0, low_power_listen_mode)
		$display("t_wake done");
	endtask : t_wake

	task t_lp;
		half = 650;
		repeat (800) @(negedge clk);
		`CHK("lpm", 1'b1, low_power_listen_mode)
		`CHK("sleep", 1'b0, slp)
		t_stream(16'h0000, 40, 60, "lp_mid");
		$display("t_lp done");
	endtask : t_lp

	task t_sleep;
		run = 0;
		repeat (150) @(negedge clk);
		`CHK("sleep", 1'b1, slp)
		`CHK("oe", 1'b0, doe)
		`CHK("settled", 1'b0, settled)
		`CHK("full", 1'b0, sready)
		half = 3000;
		run = 1;
		repeat (1500) @(negedge clk);
		`CHK("slow", 1'b1, slp)
		run = 0;
		repeat (150) @(negedge clk);
		`CHK("stopped", 1'b1, slp)
		half = 200;
		run = 1;
		wait_settled();
		`CHK("rewake", 1'b1, (n >= WAKE && n <= WAKE + 80))
		$display("t_sleep done");
	endtask : t_sleep

	task t_strap;
		int k;
		int b0;
		int d0;
		run = 0;
		svalid = 0;
		do_reset(1);
		svalid = 1;
		k = 0;
		repeat (8)
		begin
			@(negedge clk);
			k += int'(sready === 1'b1);
		end
		`CHK("taken", 2, k)
		sel = 0;
		run = 1;
		wait_settled();
		b0 = bits;
		d0 = drv;
		repeat (400) @(negedge clk);
		`CHK("left", 1'b1, (drv - d0 > 0))
		`CHK("left_all", bits - b0, drv - d0)
		$display("t_strap done");
	endtask : t_strap

	initial
	begin
		repeat (2) @(negedge clk);
		reset = 0;
		t_wake();
		t_stream(16'h7fff, 95, 100, "pos_fs");
		t_stream(16'h8000, 0, 5, "neg_fs");
		t_stream(16'h0000, 40, 60, "mid");
		t_lp();
		t_sleep();
		t_strap();
		print_verdict();
	end
endmodule : test_pmc_mic
